/* rtl/drs_defines.vh */
// Register offsets, field positions and timing constants of the status flags
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DRS_ADDR_ERR_STATUS   7'h14
`define DRS_ADDR_SLIP_STATUS  7'h15
`define DRS_ADDR_MASK1        7'h16
`define DRS_ADDR_MASK2        7'h17

// ----------------------------------------------------------------------
// Field positions of the error and slip status registers
// ----------------------------------------------------------------------
`define DRS_BIT_CS_CRC        7
`define DRS_BIT_PARITY        6
`define DRS_BIT_VALIDITY      5
`define DRS_BIT_BIPHASE       4
`define DRS_BIT_SUBCODE_CHG   3
`define DRS_BIT_UNLOCK        2
`define DRS_BIT_SUBCODE_CRC   1
`define DRS_BIT_XFER_DONE     0
`define DRS_BIT_OUT_SLIP      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DRS_RST_ERR_STATUS    8'h00
`define DRS_RST_SLIP_STATUS   8'h00
`define DRS_RST_RDATA         8'h00

// ----------------------------------------------------------------------
// Slip window: tolerance in percent of one output word period
// ----------------------------------------------------------------------
`define DRS_SLIP_WINDOW_PCT   7'h05
`define DRS_PERCENT_FULL      7'h64

`endif

/* rtl/drs_slip_detect.v */
// Frame clock slip and repeat detector for one slave serial port
`timescale 1ns/1ps
`include "drs_defines.vh"

module drs_slip_detect #(
    parameter CNT_W = 16
) (
    input  wire             i_clk_sys,
    input  wire             i_rst_n,
    input  wire             i_word_strobe,
    input  wire             i_frame_clock,
    input  wire             i_active,
    output reg              o_slip
);

    reg  [CNT_W-1:0] phase_reg;
    reg  [CNT_W-1:0] period_reg;
    reg              fclk_d_reg;
    wire [CNT_W-1:0] win_w;
    wire             fclk_edge_w;
    wire             near_end_w;
    wire             near_start_w;
    wire [CNT_W+6:0] win_prod_w;
    wire [CNT_W+6:0] win_div_w;
    wire [CNT_W:0]   end_sum_w;

    // ------------------------------------------------------------------
    // Window width, 5 percent of the measured word period
    // ------------------------------------------------------------------
    assign win_prod_w = {7'h00, period_reg} * `DRS_SLIP_WINDOW_PCT;
    assign win_div_w = win_prod_w / `DRS_PERCENT_FULL;
    // Quotient is below the period, so the upper bits are always zero
    assign win_w = win_div_w[CNT_W-1:0];
    assign fclk_edge_w = i_frame_clock ^ fclk_d_reg;
    assign near_start_w = (phase_reg <= win_w);
    // One extra bit keeps a long period from wrapping the sum
    assign end_sum_w = {1'b0, phase_reg} + {1'b0, win_w};
    assign near_end_w = (end_sum_w >= {1'b0, period_reg});

    // Phase counter restarts at each receiver output word
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            phase_reg  <= {CNT_W{1'b0}};
            period_reg <= {CNT_W{1'b0}};
            fclk_d_reg <= 1'b0;
            o_slip     <= 1'b0;
        end else begin
            fclk_d_reg <= i_frame_clock;
            if (i_word_strobe) begin
                period_reg <= phase_reg;
                phase_reg  <= {CNT_W{1'b0}};
            end else if (phase_reg != {CNT_W{1'b1}}) begin
                phase_reg <= phase_reg + 1'b1;
            end
            // Edge inside the window marks a possible slip or repeat
            o_slip <= i_active && fclk_edge_w &&
                      (period_reg != {CNT_W{1'b0}}) &&
                      (near_start_w || near_end_w);
        end
    end

endmodule

/* rtl/drs_sticky_flag.v */
// One status flag: sticky event or plain level, cleared on read
`timescale 1ns/1ps
`include "drs_defines.vh"

module drs_sticky_flag (
    input  wire             i_clk_sys,
    input  wire             i_rst_n,
    input  wire             i_sticky,
    input  wire             i_event,
    input  wire             i_clear,
    output reg              o_flag
);

    // Set wins over a clear arriving in the same cycle
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_flag <= 1'b0;
        end else if (!i_sticky) begin
            o_flag <= i_event;
        end else if (i_event) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end

endmodule

/* rtl/drs_status_flags.v */
// Receiver status flag registers with masked interrupt request
// Functional notes
// - Channel-status CRC flag is 1 on CRC error, else 0.
// - Parity and biphase flags are 1 on their error, else 0.
// - Validity flag reads 0 for valid audio, 1 for non-valid.
// - Sub-code change flag is 1 when Q-channel sub-code changes.
// - Lock loss flag is 0 when decoder and PLL locked, else 1.
// - Sub-code CRC flag is 1 on Q-channel CRC error, else 0.
// - Buffer transfer flag is 1 once buffer copy completes.
// - Output slip flag is 1 when output data slips or repeats.
// - Slip events only when receiver feeds a slave serial port.
// - With one receiver-fed port, slip flag reflects that port.
// - With both ports receiver-fed, slip flag follows port A only.
// - Frame clock edge within 5 percent window marks possible slip.
// - Slip interrupt only when unmasked in second mask register.
// - Error flag interrupts only when unmasked in first mask register.
`timescale 1ns/1ps
`include "drs_defines.vh"

module drs_status_flags #(
    parameter ADDR_W = 7,
    parameter CNT_W  = 16
) (
    input  wire              i_clk_sys,
    input  wire              i_rst_n,
    // Host register port
    input  wire [ADDR_W-1:0] i_addr,
    input  wire              i_rd_en,
    input  wire              i_wr_en,
    input  wire [7:0]        i_mask1,
    input  wire [7:0]        i_mask2,
    output reg  [7:0]        o_rdata,
    output reg               o_rvalid,
    // Receiver error sources
    input  wire              i_chan_stat_crc_err,
    input  wire              i_parity_err,
    input  wire              i_validity_flag,
    input  wire              i_biphase_err,
    input  wire              i_subcode_changed,
    input  wire              i_decoder_locked,
    input  wire              i_recovery_pll_locked,
    input  wire              i_subcode_crc_err,
    input  wire              i_rx_buffer_xfer_done,
    // Serial port routing and timing
    input  wire              i_rx_word_strobe,
    input  wire              i_port_a_from_rx,
    input  wire              i_port_a_slave,
    input  wire              i_port_a_frame_clock,
    input  wire              i_port_b_from_rx,
    input  wire              i_port_b_slave,
    input  wire              i_port_b_frame_clock,
    // Status outputs
    output reg  [7:0]        o_err_status,
    output reg               o_output_slip_err,
    output reg               o_irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    wire [7:0] raw_w;
    wire [7:0] sticky_w;
    wire [7:0] flag_w;
    wire       slip_a_w;
    wire       slip_b_w;
    wire       act_a_w;
    wire       act_b_w;
    wire       slip_evt_w;
    wire       slip_flag_w;
    wire       rd_err_w;
    wire       rd_slip_w;
    reg  [7:0] rdata_next;
    reg        irq_next;

    // ------------------------------------------------------------------
    // Raw condition vector in register bit order
    // ------------------------------------------------------------------
    assign raw_w[`DRS_BIT_CS_CRC]      = i_chan_stat_crc_err;
    assign raw_w[`DRS_BIT_PARITY]      = i_parity_err;
    assign raw_w[`DRS_BIT_VALIDITY]    = i_validity_flag;
    assign raw_w[`DRS_BIT_BIPHASE]     = i_biphase_err;
    assign raw_w[`DRS_BIT_SUBCODE_CHG] = i_subcode_changed;
    // Either loop out of lock counts as lost lock
    assign raw_w[`DRS_BIT_UNLOCK]      = ~(i_decoder_locked &
                                           i_recovery_pll_locked);
    assign raw_w[`DRS_BIT_SUBCODE_CRC] = i_subcode_crc_err;
    assign raw_w[`DRS_BIT_XFER_DONE]   = i_rx_buffer_xfer_done;

    // Change and transfer events are one-shot, so they are held until
    // read; the error levels track their source directly.
    assign sticky_w = 8'h09;

    assign rd_err_w  = i_rd_en && (i_addr == `DRS_ADDR_ERR_STATUS);
    assign rd_slip_w = i_rd_en && (i_addr == `DRS_ADDR_SLIP_STATUS);

    // ------------------------------------------------------------------
    // Per-bit flag cells
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            drs_sticky_flag u_flag (
                .i_clk_sys (i_clk_sys),
                .i_rst_n   (i_rst_n),
                .i_sticky  (sticky_w[gi]),
                .i_event   (raw_w[gi]),
                .i_clear   (rd_err_w),
                .o_flag    (flag_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Slip detection per port, gated by routing and slave mode
    // ------------------------------------------------------------------
    assign act_a_w = i_port_a_from_rx && i_port_a_slave;
    // Port B is ignored whenever port A also takes receiver data
    assign act_b_w = i_port_b_from_rx && i_port_b_slave &&
                     !i_port_a_from_rx;

    drs_slip_detect #(
        .CNT_W (CNT_W)
    ) u_slip_a (
        .i_clk_sys     (i_clk_sys),
        .i_rst_n       (i_rst_n),
        .i_word_strobe (i_rx_word_strobe),
        .i_frame_clock (i_port_a_frame_clock),
        .i_active      (act_a_w),
        .o_slip        (slip_a_w)
    );

    drs_slip_detect #(
        .CNT_W (CNT_W)
    ) u_slip_b (
        .i_clk_sys     (i_clk_sys),
        .i_rst_n       (i_rst_n),
        .i_word_strobe (i_rx_word_strobe),
        .i_frame_clock (i_port_b_frame_clock),
        .i_active      (act_b_w),
        .o_slip        (slip_b_w)
    );

    // Only the selected port can feed the flag
    assign slip_evt_w = slip_a_w | slip_b_w;

    drs_sticky_flag u_slip_flag (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_sticky  (1'b1),
        .i_event   (slip_evt_w),
        .i_clear   (rd_slip_w),
        .o_flag    (slip_flag_w)
    );

    // ------------------------------------------------------------------
    // Read mux; writes never reach the status bits
    // ------------------------------------------------------------------
    always @* begin
        rdata_next = `DRS_RST_RDATA;
        if (i_addr == `DRS_ADDR_ERR_STATUS) begin
            rdata_next = flag_w;
        end else if (i_addr == `DRS_ADDR_SLIP_STATUS) begin
            rdata_next = {7'h00, slip_flag_w};
        end
    end

    // Interrupt request from unmasked flags only
    always @* begin
        irq_next = |(flag_w & i_mask1);
        irq_next = irq_next |
                   (slip_flag_w & i_mask2[`DRS_BIT_OUT_SLIP]);
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rdata           <= `DRS_RST_RDATA;
            o_rvalid          <= 1'b0;
            o_err_status      <= `DRS_RST_ERR_STATUS;
            o_output_slip_err <= 1'b0;
            o_irq             <= 1'b0;
        end else begin
            // Write strobe during a read suppresses the read valid strobe
            o_rvalid          <= i_rd_en && !i_wr_en;
            if (i_rd_en) begin
                o_rdata <= rdata_next;
            end
            o_err_status      <= flag_w;
            o_output_slip_err <= slip_flag_w;
            o_irq             <= irq_next;
        end
    end

endmodule

/* tb/drs_status_flags_sva.sv */
// Assertion checker for the receiver status flag block
`timescale 1ns/1ps
module drs_status_flags_sva #(
    parameter ADDR_W = 7,
    parameter CNT_W  = 16
) (
    input wire              i_clk_sys,
    input wire              i_rst_n,
    input wire              i_rd_en,
    input wire              i_wr_en,
    input wire [ADDR_W-1:0] i_addr,
    input wire [7:0]        i_mask1,
    input wire [7:0]        i_mask2,
    input wire [7:0]        o_rdata,
    input wire [7:0]        o_err_status,
    input wire              o_rvalid,
    input wire              o_output_slip_err,
    input wire              o_irq,
    input wire              i_chan_stat_crc_err,
    input wire              i_parity_err,
    input wire              i_validity_flag,
    input wire              i_biphase_err,
    input wire              i_subcode_changed,
    input wire              i_decoder_locked,
    input wire              i_recovery_pll_locked,
    input wire              i_subcode_crc_err,
    input wire              i_rx_buffer_xfer_done,
    input wire              i_port_a_from_rx,
    input wire              i_port_a_slave,
    input wire              i_port_b_from_rx,
    input wire              i_port_b_slave,
    input wire              i_port_a_frame_clock
);
    // ------------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------------
    reg  [1:0] up_reg;
    wire       act_w = (i_port_a_from_rx && i_port_a_slave) ||
                       (i_port_b_from_rx && i_port_b_slave);
    // Flags lag sources by two edges, so wait two edges out of reset
    always @(posedge i_clk_sys) begin
        up_reg <= {up_reg[0], i_rst_n};
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_idle; (!act_w) [*8]; endsequence
    sequence s_a_quiet;
        (i_port_a_from_rx && i_port_b_from_rx &&
         $stable(i_port_a_frame_clock)) [*8];
    endsequence
    property p_cs_crc;
        &up_reg |-> o_err_status[7] == $past(i_chan_stat_crc_err, 2);
    endproperty
    property p_par_bip; &up_reg |-> {o_err_status[6], o_err_status[4]}
        == $past({i_parity_err, i_biphase_err}, 2); endproperty
    property p_valid;
        &up_reg |-> o_err_status[5] == $past(i_validity_flag, 2);
    endproperty
    property p_chg;
        &up_reg && $past(i_subcode_changed, 2) |-> o_err_status[3];
    endproperty
    property p_unlock; &up_reg |-> o_err_status[2] ==
        !$past(i_decoder_locked && i_recovery_pll_locked, 2); endproperty
    property p_subcode_crc_err;
        &up_reg |-> o_err_status[1] == $past(i_subcode_crc_err, 2);
    endproperty
    property p_xfer;
        &up_reg && $past(i_rx_buffer_xfer_done, 2) |-> o_err_status[0];
    endproperty
    property p_rd15; i_rd_en && !i_wr_en && i_addr == 7'h15
        |=> o_rvalid && o_rdata[7:1] == 7'h00; endproperty
    property p_irq; $stable(i_mask1) && $stable(i_mask2) |-> o_irq ==
        (|(o_err_status & i_mask1) || (o_output_slip_err && i_mask2[0]));
    endproperty
    property p_idle; s_idle |=> !$rose(o_output_slip_err); endproperty
    property p_a_only; s_a_quiet |=> !$rose(o_output_slip_err); endproperty
    a_cs_crc: assert property (p_cs_crc)
        else $error("channel status crc flag wrong");
    a_par_bip: assert property (p_par_bip)
        else $error("parity or biphase flag wrong");
    a_valid: assert property (p_valid)
        else $error("validity flag wrong");
    a_chg: assert property (p_chg)
        else $error("sub-code change flag missed");
    a_unlock: assert property (p_unlock)
        else $error("lock loss flag wrong");
    a_subcode_crc_err: assert property (p_subcode_crc_err)
        else $error("sub-code crc flag wrong");
    a_xfer: assert property (p_xfer)
        else $error("buffer transfer flag missed");
    a_rd15: assert property (p_rd15)
        else $error("slip register read wrong");
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow masked flags");
    a_idle: assert property (p_idle)
        else $error("slip raised with no slave port fed");
    a_a_only: assert property (p_a_only)
        else $error("slip raised while port A clock idle");
endmodule

bind drs_status_flags drs_status_flags_sva #(.ADDR_W(ADDR_W),
    .CNT_W(CNT_W)) sva_i (.*);

/* tb/tb.sv */
// Self-checking bench for the receiver status flag block
`timescale 1ns/1ps
module tb;
    logic        i_clk_sys, i_rst_n, i_rd_en, i_wr_en, o_rvalid;
    logic [6:0]  i_addr;
    logic [7:0]  i_mask1, i_mask2, o_rdata, o_err_status, e8;
    logic        i_chan_stat_crc_err, i_parity_err, i_validity_flag;
    logic        i_biphase_err, i_subcode_changed, i_decoder_locked;
    logic        i_recovery_pll_locked, i_subcode_crc_err, o_irq;
    logic        i_rx_buffer_xfer_done, i_rx_word_strobe, o_output_slip_err;
    logic        i_port_a_from_rx, i_port_a_slave, i_port_a_frame_clock;
    logic        i_port_b_from_rx, i_port_b_slave, i_port_b_frame_clock;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    logic [4:0]  lv;
    int          err_count, checks_done, i;
    drs_status_flags drs_status_flags_i (.*);
    // ------------------------------------------------------------------
    // Clock, word strobe every 20 cycles, watchdog
    // ------------------------------------------------------------------
    initial begin
        i_clk_sys = 0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_rx_word_strobe = 0;
        forever begin
            repeat (19) @(posedge i_clk_sys);
            #1 i_rx_word_strobe = 1;
            @(posedge i_clk_sys);
            #1 i_rx_word_strobe = 0;
        end
    end
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, ex);
        checks_done++;
        if (seen !== ex) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, ex, seen);
        end
    endtask
    // Read strobe; a read with write high must give no answer
    task automatic rd(input logic [6:0] a, input logic [7:0] m, ex,
                      input logic w = 0);
        @(posedge i_clk_sys);
        #1 i_addr = a;
        i_rd_en = 1;
        i_wr_en = w;
        if (!w) exp_q.push_back({m, ex});
        @(posedge i_clk_sys);
        #1 i_rd_en = 0;
        i_wr_en = 0;
    endtask
    // Oldest note against each answer; an unasked answer always fails
    always @(posedge i_clk_sys) begin
        if (o_rvalid === 1'b1) begin
            note = exp_q.size() ? exp_q.pop_front() : 16'h00ff;
            check("rdata", o_rdata & note[15:8], note[7:0]);
        end
    end
    // Route the receiver, toggle one frame clock at a chosen word phase
    task automatic slip(input logic [3:0] cfg, input logic use_b,
                        input int ph, input logic ex);
        {i_port_a_from_rx, i_port_a_slave,
         i_port_b_from_rx, i_port_b_slave} = cfg;
        i_mask1 = 8'h00;
        i_mask2 = 8'($urandom);
        repeat (45) @(posedge i_clk_sys);
        rd(7'h15, 8'h00, 8'h00);
        @(posedge i_rx_word_strobe);
        repeat (ph) @(posedge i_clk_sys);
        #1;
        if (use_b) i_port_b_frame_clock = ~i_port_b_frame_clock;
        else i_port_a_frame_clock = ~i_port_a_frame_clock;
        repeat (6) @(posedge i_clk_sys);
        #1 check("slip", {7'h00, o_output_slip_err}, {7'h00, ex});
        check("irq", {7'h00, o_irq}, {7'h00, ex & i_mask2[0]});
        rd(7'h15, 8'hff, {7'h00, ex});
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        note = 16'($urandom(32'h4631c1b1));
        {i_rd_en, i_wr_en, i_addr, i_mask1, i_mask2} = '0;
        {i_chan_stat_crc_err, i_parity_err, i_validity_flag} = '0;
        {i_biphase_err, i_subcode_changed, i_subcode_crc_err} = '0;
        {i_decoder_locked, i_recovery_pll_locked} = '0;
        {i_rx_buffer_xfer_done, i_port_a_from_rx, i_port_a_slave} = '0;
        {i_port_a_frame_clock, i_port_b_from_rx, i_port_b_slave} = '0;
        i_port_b_frame_clock = 0;
        i_rst_n = 0;
        repeat (6) @(posedge i_clk_sys);
        #1 i_rst_n = 1;
        rd(7'h14, 8'hff, 8'h04);
        rd(7'h15, 8'hff, 8'h00);
        // Level flags with random sources and masks
        for (i = 0; i < 12; i++) begin
            lv = 5'($urandom);
            {i_chan_stat_crc_err, i_parity_err, i_validity_flag,
             i_biphase_err, i_subcode_crc_err} = lv;
            {i_decoder_locked, i_recovery_pll_locked} = 2'($urandom);
            i_mask1 = 8'($urandom);
            i_mask2 = 8'($urandom);
            e8 = {lv[4:1], 1'b0,
                  ~(i_decoder_locked & i_recovery_pll_locked), lv[0], 1'b0};
            repeat (3) @(posedge i_clk_sys);
            rd(7'h14, 8'hf6, e8);
            check("err_status", o_err_status & 8'hf6, e8);
            check("irq", {7'h00, o_irq}, {7'h00, |(e8 & i_mask1)});
        end
        // Sticky events survive a write, clear on read
        {i_subcode_changed, i_rx_buffer_xfer_done} = 2'b11;
        @(posedge i_clk_sys);
        #1 {i_subcode_changed, i_rx_buffer_xfer_done} = 2'b00;
        i_wr_en = 1;
        i_addr = 7'h14;
        @(posedge i_clk_sys);
        #1 i_wr_en = 0;
        rd(7'h14, 8'h09, 8'h09);
        rd(7'h14, 8'h09, 8'h00);
        rd(7'h14, 8'h00, 8'h00, 1);
        rd(7'h30, 8'hff, 8'h00);
        // Slip detection per port routing and phase
        slip(4'b1100, 0, 1, 1);
        rd(7'h15, 8'hff, 8'h00);
        slip(4'b1100, 0, 10, 0);
        slip(4'b1000, 0, 1, 0);
        slip(4'b0011, 1, 0, 1);
        slip(4'b1111, 1, 1, 0);
        repeat (4) @(posedge i_clk_sys);
        check("pending", 8'(exp_q.size()), 8'h00);
        finish_test();
    end
endmodule
